// >>> scs_pkg.sv
// ==========================================================
// shared constants of the segmented configuration store
package scs_pkg;
    // ======================================================
    // sizes
    localparam int NWORDS = 34;             // active parameter words
    localparam int WW     = 32;             // parameter word width
    localparam int IW     = 6;              // word index width
    localparam int AW     = 8;              // bus byte address width
    localparam int SW     = 8;              // segment number width
    typedef logic [WW-1:0] scs_word_t;
    typedef logic [IW-1:0] scs_idx_t;
    typedef logic [SW-1:0] scs_seg_t;

    // ======================================================
    // register map (byte addresses)
    localparam logic [AW-1:0] REG_CTRL = 8'h00;  // command and segment
    localparam logic [AW-1:0] REG_STAT = 8'h04;  // block state
    localparam logic [AW-1:0] REG_IDX  = 8'h08;  // parameter word index
    localparam logic [AW-1:0] REG_DATA = 8'h0c;  // active parameter word
    localparam int CTRL_SEG_LSB = 0;
    localparam int CTRL_CMD_LSB = 8;
    localparam logic [1:0] CMD_SAVE = 2'h1;      // commit one segment
    localparam logic [1:0] CMD_DFLT = 2'h2;      // factory defaults
    localparam int ST_BUSY   = 0;
    localparam int ST_LOADED = 1;
    localparam int ST_ERR    = 2;

    // ======================================================
    // word indexes of interest
    localparam scs_idx_t W_OP_DIM   = 6'h00;
    localparam scs_idx_t W_HAVE_ALT = 6'h05;
    localparam scs_idx_t W_REF_ALT  = 6'h06;
    localparam scs_idx_t W_SRV_DIM  = 6'h1d;
    localparam scs_word_t DIM_2D    = 32'h0000_0003;
    localparam scs_word_t ZERO_WORD = 32'h0000_0000;

    // ======================================================
    // factory defaults of every parameter word
    function automatic scs_word_t dflt(input scs_idx_t i);
        unique case (i)
            6'h00: dflt = 32'h0000_0004;  // operating dimension, full 3d
            6'h01: dflt = 32'h0000_0003;  // differential mode, auto
            6'h02: dflt = 32'h0000_0001;  // dynamics, land
            6'h04: dflt = 32'h0000_001e;  // differential age limit, 30 s
            6'h07: dflt = 32'h0000_0012;  // position output options
            6'h08: dflt = 32'h0000_0002;  // velocity output options
            6'h09: dflt = 32'h0000_0001;  // time output options
            6'h0a: dflt = 32'h0000_0002;  // auxiliary output options
            6'h0b: dflt = 32'h0000_0032;  // output-selection mask byte 1
            6'h0c: dflt = 32'h0000_0021;  // output-selection mask byte 2
            6'h0d: dflt = 32'hffff_ffc0;  // automatic output mask
            6'h0e: dflt = 32'h2580_2580;  // port 0 baud in/out 9600
            6'h0f: dflt = 32'h0000_1218;  // port 0 frame: 8 odd 1, bin out
            6'h10: dflt = 32'h2580_2580;  // port 1 baud in/out 9600
            6'h11: dflt = 32'h0000_1218;  // port 1 frame
            6'h12: dflt = 32'h0000_0309;  // pulse en, utc, true pol, drv 3
            6'h14: dflt = 32'h4396_0000;  // bias threshold 300.0 m
            6'h15: dflt = 32'h3727_c5ac;  // pulse width 10.0e-6 s
            6'h16: dflt = 32'h4ac2_a532;  // x on the equator, prime meridian
            6'h1a: dflt = 32'h0000_0001;  // self-survey enabled
            6'h1b: dflt = 32'h0000_07d0;  // survey length 2000
            6'h1d: dflt = 32'h0000_0004;  // survey dimension, full 3d
            6'h1e: dflt = 32'h0000_0020;  // sentence mask, zda only
            6'h1f: dflt = 32'h0000_0001;  // sentence rate
            default: dflt = ZERO_WORD;    // flags false, zeros, 0.0
        endcase
    endfunction

    // ======================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SAVE = 2'b10,
        ST_DEF  = 2'b11
    } scs_state_e;
endpackage

// >>> scs_seg_if.sv
`timescale 1ns/100ps
// ==========================================================
// segment lookup between the sequencer and the segment map
interface scs_seg_if;
    import scs_pkg::*;
    scs_seg_t seg;      // segment number asked for
    logic     valid;    // segment exists
    scs_idx_t first;    // first word of the segment
    scs_idx_t last;     // last word of the segment
    modport seq (output seg, input valid, first, last);
    modport map (input seg, output valid, first, last);
endinterface

// >>> scs_seg_map.sv
`timescale 1ns/100ps
// ==========================================================
// segment number to word range
module scs_seg_map (
    scs_seg_if.map s    // lookup port
);
    import scs_pkg::*;

    // related words sit together; unknown segments answer not valid
    always_comb begin
        s.valid = 1'b1;
        s.first = 6'h00;
        s.last  = 6'h00;
        unique case (s.seg)
            8'h02: begin s.first = 6'h00; s.last = 6'h06; end
            8'h03: begin s.first = 6'h07; s.last = 6'h0d; end
            8'h04: begin s.first = 6'h0e; s.last = 6'h11; end
            8'h05: begin s.first = 6'h12; s.last = 6'h15; end
            8'h06: begin s.first = 6'h16; s.last = 6'h19; end
            8'h07: begin s.first = 6'h1a; s.last = 6'h1d; end
            8'h08: begin s.first = 6'h1e; s.last = 6'h20; end
            8'h0b: begin s.first = 6'h21; s.last = 6'h21; end
            default: s.valid = 1'b0;
        endcase
    end
endmodule

// >>> scs_top.sv
`timescale 1ns/100ps
// What this block does
// - at every reset the active settings are loaded from nonvolatile storage
// - a set takes effect at once; storage stays unchanged until saved
// - storage is grouped in numbered segments, saved or restored one at a time
// - a save command writes the segment's active values into storage
// - default command writes defaults to the stored segment and to active settings
// - segment 2 defaults dimension 4, diff mode 3, dynamics 1, foliage 0, age 30
// - reference altitude and its flag default to 0.0 and false
// - segment 3 mask bytes default 0x32 and 0x21, auto mask 0xffffffc0
// - segment 3 output option bytes default 0x12, 0x02, 0x01, 0x02
// - segment 4 ports default 9600 in/out, 8 odd 1, no input, binary output
// - segment 5 pulse on, utc, true, 0 offset, 300 m, 10e-6 s, driver 3
// - segment 6 position defaults to zero lat/lon/alt, position flag false
// - segment 7 survey enabled, length 2000, save flag false
// - saving during a survey may store auto or 2d as next survey dimension
// - a 2d survey uses the active reference altitude if entered, else 0
// - segment 8 sentence mask 0x20, rate 1, options 0
// - segment 11 holds a utc-valid flag defaulting false
module scs_top (
    input  wire logic                   core_clk_in,   // system clock
    input  wire logic                   reset_n_in,    // async reset, low
    input  wire logic                   ce_in,         // clock enable
    // wishbone slave
    input  wire logic                   wb_cyc_in,     // cycle
    input  wire logic                   wb_stb_in,     // strobe
    input  wire logic                   wb_we_in,      // write
    input  wire logic [scs_pkg::AW-1:0] wb_adr_in,     // byte address
    input  wire logic [3:0]             wb_sel_in,     // byte lanes
    input  wire logic [31:0]            wb_dat_in,     // write data
    output logic      [31:0]            wb_dat_out,    // read data
    output logic                        wb_ack_out,    // acknowledge
    // nonvolatile storage port
    output logic                        nv_req_out,    // access request
    output logic                        nv_we_out,     // write access
    output logic      [scs_pkg::IW-1:0] nv_addr_out,   // word address
    output logic      [scs_pkg::WW-1:0] nv_wdata_out,  // write word
    input  wire logic                   nv_ack_in,     // access done
    input  wire logic [scs_pkg::WW-1:0] nv_rdata_in,   // read word
    // survey interface
    input  wire logic                   survey_run_in, // survey running
    output logic      [scs_pkg::WW-1:0] survey_dim_out,// dimension to use
    output logic      [scs_pkg::WW-1:0] survey_alt_out,// 2d altitude
    // active configuration, all words flattened
    output logic [scs_pkg::NWORDS*scs_pkg::WW-1:0] cfg_out  // active words
);
    import scs_pkg::*;

    // elaboration guards: the index and byte-lane logic serve only these sizes
    if (NWORDS > (1 << IW)) begin : g_bad_idx
        $error("word index too narrow");
    end
    if (WW != 32) begin : g_bad_ww
        $error("parameter words must be 32 bits");
    end

    // ======================================================
    // declarations
    scs_word_t  act_reg [NWORDS];
    scs_state_e state_reg;
    scs_idx_t   ptr_reg;
    scs_idx_t   last_reg;
    scs_idx_t   idx_reg;
    logic       loaded_reg;
    logic       err_reg;
    logic       req_reg;
    logic       ack_reg;
    logic       srv_sub_reg;
    scs_word_t  rdat_reg;
    logic       wb_req;
    logic       wr_ctrl;
    logic       wr_data;
    logic       nv_done;
    logic [1:0] cmd_code;
    scs_word_t  save_word;
    scs_word_t  wmask;
    scs_seg_if  seg_if ();

    // ======================================================
    // segment lookup
    assign seg_if.seg = wb_dat_in[CTRL_SEG_LSB +: SW];

    scs_seg_map u_map (
        .s (seg_if.map)
    );

    // ======================================================
    // bus decode
    // a request is answered one cycle after it is seen, then ack drops
    assign wb_req   = wb_cyc_in & wb_stb_in & ~ack_reg;
    assign wr_ctrl  = wb_req & wb_we_in & (wb_adr_in == REG_CTRL) & wb_sel_in[1];
    assign wr_data  = wb_req & wb_we_in & (wb_adr_in == REG_DATA);
    assign cmd_code = wb_dat_in[CTRL_CMD_LSB +: 2];
    assign nv_done  = req_reg & nv_ack_in;

    // byte lanes select which bytes of the parameter word change
    always_comb begin
        wmask = ZERO_WORD;
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{wb_sel_in[b]}};
        end
    end

    // acknowledge, one cycle wide
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_reg <= 1'b0;
        end else if (ce_in) begin
            ack_reg <= wb_req;
        end
    end

    // read data; unmapped addresses read zero
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdat_reg <= ZERO_WORD;
        end else if (ce_in && wb_req) begin
            unique case (wb_adr_in)
                REG_STAT: begin
                    rdat_reg           <= ZERO_WORD;
                    rdat_reg[ST_BUSY]  <= state_reg != ST_IDLE;
                    rdat_reg[ST_LOADED]<= loaded_reg;
                    rdat_reg[ST_ERR]   <= err_reg;
                end
                REG_IDX:  rdat_reg <= {{(WW-IW){1'b0}}, idx_reg};
                REG_DATA: rdat_reg <= (idx_reg < NWORDS[IW-1:0]) ?
                                      act_reg[idx_reg] : ZERO_WORD;
                default:  rdat_reg <= ZERO_WORD;
            endcase
        end
    end

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = rdat_reg;

    // word index register
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            idx_reg <= 6'h00;
        end else if (ce_in && wb_req && wb_we_in && wb_adr_in == REG_IDX
                     && wb_sel_in[0]) begin
            idx_reg <= wb_dat_in[IW-1:0];
        end
    end

    // ======================================================
    // command sequencer
    // commands arriving while busy are dropped; status shows busy
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_LOAD;
            ptr_reg   <= 6'h00;
            last_reg  <= 6'(NWORDS - 1);
        end else if (ce_in) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (wr_ctrl && seg_if.valid) begin
                        if (cmd_code == CMD_SAVE) begin
                            state_reg <= ST_SAVE;
                        end else if (cmd_code == CMD_DFLT) begin
                            state_reg <= ST_DEF;
                        end
                        ptr_reg  <= seg_if.first;
                        last_reg <= seg_if.last;
                    end
                end
                ST_LOAD, ST_SAVE, ST_DEF: begin
                    if (nv_done) begin
                        if (ptr_reg == last_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            ptr_reg <= ptr_reg + 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    // load complete flag and bad segment flag
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            loaded_reg <= 1'b0;
            err_reg    <= 1'b0;
        end else if (ce_in) begin
            if (state_reg == ST_LOAD && nv_done && ptr_reg == last_reg) begin
                loaded_reg <= 1'b1;
            end
            if (state_reg == ST_IDLE && wr_ctrl) begin
                err_reg <= ~seg_if.valid;
            end
        end
    end

    // ======================================================
    // survey-running capture
    // a save that starts while a survey runs records the live dimension
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            srv_sub_reg <= 1'b0;
        end else if (ce_in && state_reg == ST_IDLE && wr_ctrl) begin
            srv_sub_reg <= survey_run_in;
        end
    end

    // word sent to storage on a save
    always_comb begin
        save_word = act_reg[ptr_reg];
        if (ptr_reg == W_SRV_DIM && srv_sub_reg) begin
            save_word = act_reg[W_OP_DIM];
        end
    end

    // ======================================================
    // storage access
    // the request stays up until the storage acknowledges
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_reg      <= 1'b0;
            nv_we_out    <= 1'b0;
            nv_addr_out  <= 6'h00;
            nv_wdata_out <= ZERO_WORD;
        end else if (ce_in) begin
            if (nv_done || state_reg == ST_IDLE) begin
                req_reg <= 1'b0;
            end else if (!req_reg) begin
                req_reg     <= 1'b1;
                nv_we_out   <= state_reg != ST_LOAD;
                nv_addr_out <= ptr_reg;
                nv_wdata_out <= (state_reg == ST_DEF) ?
                                dflt(ptr_reg) : save_word;
            end
        end
    end

    assign nv_req_out = req_reg;

    // ======================================================
    // active parameter words
    // reset values are the factory defaults so outputs are sane while
    // the stored copy is being read back in
    for (genvar g = 0; g < NWORDS; g++) begin : g_act
        localparam scs_idx_t GI = IW'(g);
        always_ff @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                act_reg[g] <= dflt(GI);
            end else if (ce_in) begin
                if (state_reg == ST_LOAD && nv_done && ptr_reg == GI) begin
                    act_reg[g] <= nv_rdata_in;
                end else if (state_reg == ST_DEF && nv_done
                             && ptr_reg == GI) begin
                    act_reg[g] <= dflt(GI);
                end else if (state_reg == ST_IDLE && wr_data
                             && idx_reg == GI) begin
                    act_reg[g] <= (act_reg[g] & ~wmask)
                                | (wb_dat_in & wmask);
                end
            end
        end
        assign cfg_out[g*WW +: WW] = act_reg[g];
    end

    // ======================================================
    // survey outputs
    // a 2d survey without an entered altitude falls back to zero height
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            survey_dim_out <= dflt(W_SRV_DIM);
            survey_alt_out <= ZERO_WORD;
        end else if (ce_in) begin
            survey_dim_out <= act_reg[W_SRV_DIM];
            if (act_reg[W_SRV_DIM] == DIM_2D
                && act_reg[W_HAVE_ALT] != ZERO_WORD) begin
                survey_alt_out <= act_reg[W_REF_ALT];
            end else begin
                survey_alt_out <= ZERO_WORD;
            end
        end
    end
endmodule

// >>> scs_properties.sv
`timescale 1ns/100ps
// ==========================================================
// port-level checks of the configuration store
module scs_properties (
    input wire logic          core_clk_in,    // system clock
    input wire logic          reset_n_in,     // async reset, low
    input wire logic          ce_in,          // clock enable
    input wire logic          wb_cyc_in,      // cycle
    input wire logic          wb_stb_in,      // strobe
    input wire logic [31:0]   wb_dat_out,     // read data
    input wire logic          wb_ack_out,     // acknowledge
    input wire logic          nv_req_out,     // storage request
    input wire logic          nv_we_out,      // storage write
    input wire logic [5:0]    nv_addr_out,    // storage address
    input wire logic [31:0]   nv_wdata_out,   // storage write word
    input wire logic          nv_ack_in,      // storage done
    input wire logic [31:0]   survey_dim_out, // survey dimension
    input wire logic [31:0]   survey_alt_out, // survey altitude
    input wire logic [1087:0] cfg_out         // active words
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic seen_reg;  // a storage access was made since reset
    // remembers the first access, which must open the reload
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            seen_reg <= 1'b0;
        end else if (nv_req_out) begin
            seen_reg <= 1'b1;
        end
    end
    // steps of a bus transfer and of a storage access
    sequence bus_take; wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in; endsequence
    sequence nv_wait;  nv_req_out && !nv_ack_in; endsequence
    sequence nv_done;  nv_req_out && nv_ack_in && ce_in; endsequence
    bus_ack_a: assert property (bus_take |=> wb_ack_out)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
        else $error("acknowledge longer than one cycle");
    dat_hold_a: assert property (!wb_ack_out |-> $stable(wb_dat_out))
        else $error("read data moved without acknowledge");
    nv_hold_a: assert property (nv_wait |=> nv_req_out && $stable(nv_addr_out) &&
        $stable(nv_we_out) && $stable(nv_wdata_out))
        else $error("storage request dropped or changed before its answer");
    nv_drop_a: assert property (nv_done |=> !nv_req_out)
        else $error("storage request held after its answer");
    load_first_a: assert property (nv_req_out && !seen_reg |-> !nv_we_out &&
        nv_addr_out == 6'h00)
        else $error("first access after reset is not a read of word 0");
    survey_dim_a: assert property ($past(ce_in) |->
        survey_dim_out == $past(cfg_out[928+:32]))
        else $error("survey dimension does not follow its active word");
    // a 2d survey takes the entered altitude, else zero
    survey_alt_a: assert property ($past(ce_in) |-> survey_alt_out ==
        (($past(cfg_out[928+:32]) == 32'h3 && $past(cfg_out[160+:32]) != 32'h0) ?
        $past(cfg_out[192+:32]) : 32'h0))
        else $error("survey altitude wrong");
endmodule

// >>> scs_nv_model.sv
`timescale 1ns/100ps
// ==========================================================
// word-wide nonvolatile store behind the storage port
module scs_nv_model (
    input  wire logic        clk_in,   // system clock
    input  wire logic        req_in,   // access request
    input  wire logic        we_in,    // write access
    input  wire logic [5:0]  addr_in,  // word address
    input  wire logic [31:0] wdata_in, // write word
    output logic             ack_out,  // access done
    output logic [31:0]      rdata_out // read word
);
    logic [31:0] mem [34];  // contents survive every reset of the block
    int          wait_cnt;  // cycles already waited on this access
    initial begin
        for (int i = 0; i < 34; i++) begin
            mem[i] = 32'ha500_0000 + i;
        end
        ack_out = 1'b0;
        rdata_out = 32'h0;
        wait_cnt = 0;
    end
    // answer after 0..3 cycles chosen by the address, so replies are prompt and slow;
    // ack stays up until the request drops, as a frozen block may sample it late
    always @(posedge clk_in) begin
        if (req_in && !ack_out) begin
            if (wait_cnt >= int'(addr_in[1:0])) begin
                ack_out <= 1'b1;
                wait_cnt <= 0;
                rdata_out <= mem[addr_in];
                if (we_in) begin
                    mem[addr_in] <= wdata_in;
                end
            end else begin
                wait_cnt <= wait_cnt + 1;
                rdata_out <= ~rdata_out;  // not valid yet: keep it moving
            end
        end else if (!req_in) begin
            ack_out <= 1'b0;
            rdata_out <= ~rdata_out;
        end
    end
endmodule

// >>> scs_top_bench.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench of the configuration store
module scs_top_bench;
    import scs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b0;
    logic ack, nv_req, nv_we, nv_ack;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, nv_wd, nv_rd, sdim, salt, q;
    logic [5:0]  nv_adr;
    logic [1087:0] cfg;
    scs_word_t act [NWORDS];  // expected active words
    scs_word_t nvm [NWORDS];  // expected stored words
    scs_word_t dv [NWORDS] = '{32'h4, 32'h3, 32'h1, 32'h0, 32'h1e, 32'h0, 32'h0, 32'h12,
        32'h2, 32'h1, 32'h2, 32'h32, 32'h21, 32'hffffffc0, 32'h25802580, 32'h1218,
        32'h25802580, 32'h1218, 32'h309, 32'h0, 32'h43960000, 32'h3727c5ac,
        32'h4ac2a532, 32'h0, 32'h0, 32'h0, 32'h1, 32'h7d0, 32'h0, 32'h4,
        32'h20, 32'h1, 32'h0, 32'h0};
    int segf [12] = '{0, 0, 0, 7, 14, 18, 22, 26, 30, 0, 0, 33};
    int segl [12] = '{-1, -1, 6, 13, 17, 21, 25, 29, 32, -1, -1, 33};
    int segs [8] = '{2, 3, 4, 5, 6, 7, 8, 11};
    int miscompares = 0, comparisons = 0, seed = 67;

    scs_top scs_top_i (.core_clk_in(clk), .reset_n_in(rst_n), .ce_in(ce),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .nv_req_out(nv_req),
        .nv_we_out(nv_we), .nv_addr_out(nv_adr), .nv_wdata_out(nv_wd), .nv_ack_in(nv_ack),
        .nv_rdata_in(nv_rd), .survey_run_in(run), .survey_dim_out(sdim),
        .survey_alt_out(salt), .cfg_out(cfg));
    scs_nv_model scs_nv_model_i (.clk_in(clk), .req_in(nv_req), .we_in(nv_we),
        .addr_in(nv_adr), .wdata_in(nv_wd), .ack_out(nv_ack), .rdata_out(nv_rd));

    // clock, and an enable that drops a quarter of the time to stretch every wait
    always #25 clk = ~clk;
    always @(posedge clk) ce <= ($random(seed) % 4) != 0;

    task automatic close_out;
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one classic cycle; waits out a frozen ack before raising a new request
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n = 0;
        @(posedge clk);
        while (ack !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (ack !== 1'b0) begin
            miscompares++;
            close_out();
        end
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 200);
        if (ack !== 1'b1) begin
            miscompares++;
            close_out();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic waitbit(input int b, input logic v);
        int n = 0;
        do begin
            bus(1'b0, REG_STAT, 32'h0, 4'hf);
            n++;
        end while (q[b] !== v && n < 300);
        if (n >= 300) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic chk_all;
        for (int i = 0; i < NWORDS; i++) begin
            cmp($sformatf("active word %0d", i), cfg[i*WW+:WW], act[i]);
            cmp($sformatf("stored word %0d", i), scs_nv_model_i.mem[i], nvm[i]);
        end
    endtask
    // reset mid-run too: the reload must rebuild the active words from storage
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        act = nvm;
        waitbit(ST_LOADED, 1'b1);
        waitbit(ST_BUSY, 1'b0);
    endtask
    task automatic setw(input int i, input logic [31:0] d, input logic [3:0] s);
        bus(1'b1, REG_IDX, 32'(i), 4'hf);
        bus(1'b0, REG_IDX, 32'h0, 4'hf);
        cmp("index readback", q, 32'(i));
        bus(1'b1, REG_DATA, d, s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) act[i][b*8+:8] = d[b*8+:8];
        end
        bus(1'b0, REG_DATA, 32'h0, 4'hf);
        cmp("data readback", q, act[i]);
    endtask
    task automatic cmd(input logic [1:0] c, input int s);
        logic ok;
        ok = s < 12 && segl[s] >= 0;
        bus(1'b1, REG_CTRL, {22'h0, c, s[7:0]}, 4'hf);
        waitbit(ST_BUSY, 1'b0);
        if (ok && (c == CMD_SAVE || c == CMD_DFLT)) begin
            for (int w = segf[s]; w <= segl[s]; w++) begin
                if (c == CMD_SAVE) begin
                    nvm[w] = (s == 7 && w == 29 && run) ? act[0] : act[w];
                end else begin
                    act[w] = dv[w];
                    nvm[w] = dv[w];
                end
            end
        end
        if (c == CMD_SAVE || c == CMD_DFLT) begin
            bus(1'b0, REG_STAT, 32'h0, 4'hf);
            cmp("error flag", {31'h0, q[ST_ERR]}, {31'h0, !ok});
        end
    endtask

    initial begin
        for (int i = 0; i < NWORDS; i++) nvm[i] = 32'ha500_0000 + i;
        do_reset();
        chk_all();
        setw(0, DIM_2D, 4'hf);
        setw(6, $random(seed), 4'h5);
        setw(13, $random(seed), 4'hf);
        chk_all();
        cmd(CMD_SAVE, 2);
        chk_all();
        @(posedge clk);
        run <= 1'b1;
        cmd(CMD_SAVE, 7);
        @(posedge clk);
        run <= 1'b0;
        cmd(CMD_SAVE, 9);
        cmd(2'h3, 3);
        chk_all();
        do_reset();
        chk_all();
        cmp("survey dimension", sdim, DIM_2D);
        setw(5, 32'h1, 4'hf);
        setw(6, $random(seed), 4'hf);
        cmp("entered altitude", salt, act[6]);
        setw(5, 32'h0, 4'hf);
        cmp("zero altitude", salt, 32'h0);
        for (int k = 0; k < 8; k++) begin
            cmd(CMD_DFLT, segs[k]);
            chk_all();
        end
        cmd(CMD_DFLT, 9);
        cmd(CMD_SAVE, 255);
        chk_all();
        bus(1'b0, 8'h10, 32'h0, 4'hf);
        cmp("unmapped read", q, 32'h0);
        close_out();
    end
endmodule

bind scs_top scs_properties scs_properties_i (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .nv_req_out(nv_req_out),
    .nv_we_out(nv_we_out), .nv_addr_out(nv_addr_out), .nv_wdata_out(nv_wdata_out),
    .nv_ack_in(nv_ack_in), .survey_dim_out(survey_dim_out),
    .survey_alt_out(survey_alt_out), .cfg_out(cfg_out));
